// ---- logic/fcp_pkg.sv ----
// Constants, types and sequences for the flash command/poll host controller.
// Assumes a parallel NOR flash on asynchronous pins; one 100 MHz clock here.
// Contract
// - Confirm buffer program by writing 29h
// - Reset loses suspended program; host reprograms
// - Reset kills erase; host reissues chip erase
// - Sector erase: unlock, setup, unlock, sector
// - Poll after erase; clear error with reset
// - Return to read mode before resume
// - Blank check: setup then 29h confirm
package fcp_pkg;
	localparam int FCP_ADDR_W = 22;
	localparam int FCP_DATA_W = 16;
	localparam int CLK_PERIOD_NS = 10;

	// Command data bytes
	localparam logic [7:0] CMD_UNLOCK1 = 8'hAA;
	localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
	localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
	localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
	localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
	localparam logic [7:0] CMD_RESUME = 8'h30;
	localparam logic [7:0] CMD_SUSPEND = 8'hB0;
	localparam logic [7:0] CMD_CONFIRM = 8'h29;
	localparam logic [7:0] CMD_BLANK_SETUP1 = 8'hEB;
	localparam logic [7:0] CMD_BLANK_SETUP2 = 8'h76;
	localparam logic [7:0] CMD_READ_RESET = 8'hF0;

	// Unlock cycle word addresses
	localparam logic [FCP_ADDR_W-1:0] UNLOCK_ADDR1 = 22'h000555;
	localparam logic [FCP_ADDR_W-1:0] UNLOCK_ADDR2 = 22'h0002AA;

	// Status bit positions
	localparam int POLL_BIT = 7;
	localparam int TOGGLE_BIT = 6;
	localparam int FAIL_BIT = 5;
	localparam int WINDOW_BIT = 3;
	localparam int SECTOR_TOGGLE_BIT = 2;
	localparam int ABORT_BIT = 1;

	// Bus timing, least times round up
	localparam int WE_LOW_NS = 40;
	localparam int WR_RECOV_NS = 20;
	localparam int RD_ACCESS_NS = 70;
	localparam int SYNC_STAGES = 3;
	localparam int WE_LOW_CYC = (WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WR_RECOV_CYC =
		(WR_RECOV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RD_CYC =
		(RD_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES;
	// Worst-case program suspend latency
	localparam int SUSP_LAT_NS = 15000;
	localparam int SUSP_LAT_CYC =
		(SUSP_LAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [3:0] {
		OP_READ = 4'h0,
		OP_RESET = 4'h1,
		OP_CONFIRM = 4'h2,
		OP_SUSPEND = 4'h3,
		OP_RESUME = 4'h4,
		OP_CHIP_ERASE = 4'h5,
		OP_SECTOR_ERASE = 4'h6,
		OP_ADD_SECTOR = 4'h7,
		OP_BLANK_CHECK = 4'h8,
		OP_POLL = 4'h9
	} fcp_op_type;

	typedef struct packed {
		fcp_op_type op;
		logic [FCP_ADDR_W-1:0] addr;
	} fcp_req_type;

	typedef struct packed {
		logic [FCP_ADDR_W-1:0] addr;
		logic [FCP_DATA_W-1:0] data;
	} fcp_wr_type;

	typedef struct packed {
		logic we_n;
		logic oe_n;
		logic ce_n;
		logic dq_oe_n;
		logic [FCP_ADDR_W-1:0] addr;
		logic [FCP_DATA_W-1:0] dq_out;
	} fcp_pins_type;

	// Number of write cycles in an operation
	function automatic logic [2:0] fcp_seq_len(input fcp_op_type op);
		case (op)
			OP_CHIP_ERASE: fcp_seq_len = 3'h6;
			OP_SECTOR_ERASE: fcp_seq_len = 3'h6;
			OP_BLANK_CHECK: fcp_seq_len = 3'h3;
			OP_RESUME: fcp_seq_len = 3'h2;
			default: fcp_seq_len = 3'h1;
		endcase
	endfunction

	// Address and data of one write step
	function automatic fcp_wr_type fcp_seq_step(input fcp_op_type op,
		input logic [2:0] step, input logic [FCP_ADDR_W-1:0] addr);
		fcp_wr_type w;
		logic [7:0] last;
		w.addr = addr;
		w.data = 16'h0000;
		last = (op == OP_CHIP_ERASE) ? CMD_CHIP_ERASE : CMD_SECTOR_ERASE;
		case (op)
			OP_CHIP_ERASE, OP_SECTOR_ERASE:
			begin
				case (step)
					3'h0, 3'h3:
					begin
						w.addr = UNLOCK_ADDR1;
						w.data = {8'h00, CMD_UNLOCK1};
					end
					3'h1, 3'h4:
					begin
						w.addr = UNLOCK_ADDR2;
						w.data = {8'h00, CMD_UNLOCK2};
					end
					3'h2:
					begin
						w.addr = UNLOCK_ADDR1;
						w.data = {8'h00, CMD_ERASE_SETUP};
					end
					default:
					begin
						if (op == OP_CHIP_ERASE)
							w.addr = UNLOCK_ADDR1;
						w.data = {8'h00, last};
					end
				endcase
			end
			OP_BLANK_CHECK:
			begin
				case (step)
					3'h0: w.data = {8'h00, CMD_BLANK_SETUP1};
					3'h1: w.data = {8'h00, CMD_BLANK_SETUP2};
					default: w.data = {8'h00, CMD_CONFIRM};
				endcase
			end
			OP_RESUME:
				w.data = {8'h00, (step == 3'h0) ? CMD_READ_RESET : CMD_RESUME};
			OP_CONFIRM: w.data = {8'h00, CMD_CONFIRM};
			OP_SUSPEND: w.data = {8'h00, CMD_SUSPEND};
			OP_ADD_SECTOR: w.data = {8'h00, CMD_SECTOR_ERASE};
			default: w.data = {8'h00, CMD_READ_RESET};
		endcase
		return w;
	endfunction
endpackage

// ---- logic/fcp_bus_cycle.sv ----
// One asynchronous flash bus cycle, write or read, on the pins.
// Assumes the caller waits for done before starting another cycle.
`timescale 1ns/10ps
module fcp_bus_cycle
	import fcp_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic start,
	input wire logic is_read,
	input wire fcp_wr_type wr,
	input wire logic [FCP_DATA_W-1:0] dq_in,
	output fcp_pins_type pins,
	output logic done,
	output logic [FCP_DATA_W-1:0] rdata
);
	typedef enum logic [3:0] {
		B_IDLE = 4'b0001,
		B_SETUP = 4'b0010,
		B_STROBE = 4'b0100,
		B_RECOV = 4'b1000
	} fcp_bstate_type;

	fcp_bstate_type state_reg, state_next;
	fcp_pins_type pins_reg, pins_next;
	logic rd_reg, rd_next;
	logic done_reg, done_next;
	logic [7:0] cnt_reg, cnt_next;
	logic [FCP_DATA_W-1:0] rdata_reg, rdata_next;
	logic [FCP_DATA_W-1:0] s1_reg, s2_reg, s3_reg, stable_reg, stable_next;

	// Three-stage capture; a change counts when stages two and three agree
	always_comb
	begin
		stable_next = (s2_reg == s3_reg) ? s3_reg : stable_reg;
	end

	// Cycle sequencer: setup, strobe, recovery
	always_comb
	begin
		state_next = state_reg;
		pins_next = pins_reg;
		rd_next = rd_reg;
		cnt_next = cnt_reg;
		rdata_next = rdata_reg;
		done_next = 1'b0;
		case (state_reg)
			B_IDLE:
			begin
				if (start)
				begin
					pins_next.addr = wr.addr;
					pins_next.dq_out = wr.data;
					pins_next.ce_n = 1'b0;
					pins_next.dq_oe_n = is_read;
					rd_next = is_read;
					state_next = B_SETUP;
				end
			end
			B_SETUP:
			begin
				pins_next.we_n = rd_reg;
				pins_next.oe_n = !rd_reg;
				cnt_next = rd_reg ? 8'(RD_CYC) : 8'(WE_LOW_CYC);
				state_next = B_STROBE;
			end
			B_STROBE:
			begin
				cnt_next = cnt_reg - 8'h01;
				if (cnt_reg == 8'h01)
				begin
					pins_next.we_n = 1'b1;
					pins_next.oe_n = 1'b1;
					rdata_next = stable_reg;
					cnt_next = 8'(WR_RECOV_CYC);
					state_next = B_RECOV;
				end
			end
			B_RECOV:
			begin
				// Data held past the rising strobe for hold time
				cnt_next = cnt_reg - 8'h01;
				if (cnt_reg == 8'h01)
				begin
					pins_next.ce_n = 1'b1;
					pins_next.dq_oe_n = 1'b1;
					done_next = 1'b1;
					state_next = B_IDLE;
				end
			end
			default: state_next = B_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_reg <= B_IDLE;
			pins_reg <= '{we_n: 1'b1, oe_n: 1'b1, ce_n: 1'b1, dq_oe_n: 1'b1,
				addr: '0, dq_out: '0};
			rd_reg <= 1'b0;
			cnt_reg <= 8'h00;
			done_reg <= 1'b0;
			rdata_reg <= '0;
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			stable_reg <= '0;
		end
		else
		begin
			state_reg <= state_next;
			pins_reg <= pins_next;
			rd_reg <= rd_next;
			cnt_reg <= cnt_next;
			done_reg <= done_next;
			rdata_reg <= rdata_next;
			s1_reg <= dq_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			stable_reg <= stable_next;
		end
	end

	assign pins = pins_reg;
	assign done = done_reg;
	assign rdata = rdata_reg;

	AST_WE_NEEDS_CE: assert property (@(posedge core_clk) disable iff (!rst_n)
		!pins_reg.we_n |-> (!pins_reg.ce_n && !pins_reg.dq_oe_n))
		else $error("write strobe without chip select or data drive");
	AST_NO_CONTENTION: assert property (@(posedge core_clk)
		disable iff (!rst_n)
		!(!pins_reg.oe_n && !pins_reg.dq_oe_n))
		else $error("output enable while host drives data");
	AST_WE_WIDTH: assert property (@(posedge core_clk) disable iff (!rst_n)
		$fell(pins_reg.we_n) |-> (!pins_reg.we_n)[*4] ##1 pins_reg.we_n)
		else $error("write strobe width wrong");
endmodule

// ---- logic/fcp_host.sv ----
// Host controller: issues flash command sequences and polls status.
// Assumes a single requester that waits for req_ready before a new order.
`timescale 1ns/10ps
module fcp_host
	import fcp_pkg::*;
#(
	parameter int POLL_LIMIT = 1000000,
	parameter int SUSP_WAIT = SUSP_LAT_CYC
)
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic req_valid,
	input wire fcp_req_type req,
	output logic req_ready,
	output logic resp_valid,
	output logic resp_err,
	output logic [FCP_DATA_W-1:0] resp_data,
	output logic suspended,
	output logic chip_erase_busy,
	input wire logic [FCP_DATA_W-1:0] flash_dq_in,
	output logic [FCP_DATA_W-1:0] flash_dq_out,
	output logic flash_dq_oe_n,
	output logic [FCP_ADDR_W-1:0] flash_addr,
	output logic flash_we_n,
	output logic flash_oe_n,
	output logic flash_ce_n
);
	if (POLL_LIMIT < 1 || POLL_LIMIT > 32'h7FFFFFFF)
		$error("POLL_LIMIT out of range");
	if (SUSP_WAIT < 1 || SUSP_WAIT > 32'h00FFFFFF)
		$error("SUSP_WAIT out of range");

	typedef enum logic [5:0] {
		M_IDLE = 6'b000001,
		M_WRITE = 6'b000010,
		M_WWAIT = 6'b000100,
		M_READ = 6'b001000,
		M_RWAIT = 6'b010000,
		M_LAT = 6'b100000
	} fcp_mstate_type;

	fcp_mstate_type state_reg, state_next;
	fcp_op_type op_reg, op_next;
	logic [FCP_ADDR_W-1:0] addr_reg, addr_next;
	logic [2:0] step_reg, step_next;
	logic first_reg, first_next;
	logic [FCP_DATA_W-1:0] prev_reg, prev_next;
	logic [31:0] cnt_reg, cnt_next;
	logic recover_reg, recover_next;
	logic susp_reg, susp_next;
	logic chip_reg, chip_next;
	logic ready_reg, ready_next;
	logic rv_reg, rv_next;
	logic err_reg, err_next;
	logic [FCP_DATA_W-1:0] data_reg, data_next;
	logic start_reg, start_next;
	logic rd_reg, rd_next;
	fcp_wr_type wr_reg, wr_next;
	fcp_pins_type pins;
	logic bus_done;
	logic [FCP_DATA_W-1:0] bus_rdata;
	logic toggling, failed;

	fcp_bus_cycle u_bus (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.start(start_reg),
		.is_read(rd_reg),
		.wr(wr_reg),
		.dq_in(flash_dq_in),
		.pins(pins),
		.done(bus_done),
		.rdata(bus_rdata)
	);

	assign toggling = (bus_rdata[TOGGLE_BIT] != prev_reg[TOGGLE_BIT]);
	// failure or abort must show on two reads in a row; the read
	// that ends a busy phase carries array data whose bit 5 may be set
	assign failed = (bus_rdata[FAIL_BIT] && prev_reg[FAIL_BIT]) ||
		(bus_rdata[ABORT_BIT] && prev_reg[ABORT_BIT]);

	// Sequencer; long polls free the requester only at the end
	always_comb
	begin
		state_next = state_reg;
		op_next = op_reg;
		addr_next = addr_reg;
		step_next = step_reg;
		first_next = first_reg;
		prev_next = prev_reg;
		cnt_next = cnt_reg;
		recover_next = recover_reg;
		susp_next = susp_reg;
		chip_next = chip_reg;
		ready_next = ready_reg;
		err_next = err_reg;
		data_next = data_reg;
		wr_next = wr_reg;
		rd_next = rd_reg;
		start_next = 1'b0;
		rv_next = 1'b0;
		case (state_reg)
			M_IDLE:
			begin
				if (req_valid && ready_reg)
				begin
					ready_next = 1'b0;
					op_next = req.op;
					addr_next = req.addr;
					step_next = 3'h0;
					first_next = 1'b1;
					cnt_next = 32'h0;
					recover_next = 1'b0;
					// no suspend while chip erase runs
					if ((req.op == OP_SUSPEND && chip_reg) ||
						(req.op == OP_RESUME && !susp_reg))
					begin
						err_next = 1'b1;
						rv_next = 1'b1;
						ready_next = 1'b1;
					end
					else if (req.op == OP_READ || req.op == OP_POLL)
						state_next = M_READ;
					else
					begin
						if (req.op == OP_CHIP_ERASE)
							chip_next = 1'b1;
						if (req.op == OP_RESUME)
							susp_next = 1'b0;
						state_next = M_WRITE;
					end
				end
			end
			M_WRITE:
			begin
				wr_next = fcp_seq_step(op_reg, step_reg, addr_reg);
				rd_next = 1'b0;
				start_next = 1'b1;
				state_next = M_WWAIT;
			end
			M_WWAIT:
			begin
				if (bus_done)
				begin
					if (step_reg == fcp_seq_len(op_reg) - 3'h1)
					begin
						if (op_reg == OP_SUSPEND)
						begin
							cnt_next = 32'(SUSP_WAIT);
							state_next = M_LAT;
						end
						else
						begin
							if (op_reg == OP_RESET)
								chip_next = 1'b0;
							err_next = recover_reg;
							rv_next = 1'b1;
							ready_next = 1'b1;
							state_next = M_IDLE;
						end
					end
					else
					begin
						step_next = step_reg + 3'h1;
						state_next = M_WRITE;
					end
				end
			end
			M_LAT:
			begin
				cnt_next = cnt_reg - 32'h1;
				if (cnt_reg == 32'h1)
				begin
					susp_next = 1'b1;
					op_next = OP_POLL;
					first_next = 1'b1;
					state_next = M_READ;
				end
			end
			M_READ:
			begin
				wr_next = '{addr: addr_reg, data: '0};
				rd_next = 1'b1;
				start_next = 1'b1;
				state_next = M_RWAIT;
			end
			M_RWAIT:
			begin
				if (bus_done)
				begin
					prev_next = bus_rdata;
					first_next = 1'b0;
					state_next = M_READ;
					if (op_reg == OP_READ || (!first_reg && !toggling))
					begin
						if (op_reg == OP_POLL)
							chip_next = 1'b0;
						data_next = bus_rdata;
						err_next = 1'b0;
						rv_next = 1'b1;
						ready_next = 1'b1;
						state_next = M_IDLE;
					end
					else if (!first_reg && failed)
					begin
						op_next = OP_RESET;
						step_next = 3'h0;
						recover_next = 1'b1;
						chip_next = 1'b0;
						data_next = bus_rdata;
						state_next = M_WRITE;
					end
					else if (!first_reg)
					begin
						cnt_next = cnt_reg + 32'h1;
						if (cnt_reg == 32'(POLL_LIMIT - 1))
						begin
							data_next = bus_rdata;
							err_next = 1'b1;
							rv_next = 1'b1;
							ready_next = 1'b1;
							state_next = M_IDLE;
						end
					end
				end
			end
			default: state_next = M_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_reg <= M_IDLE;
			op_reg <= OP_READ;
			addr_reg <= '0;
			step_reg <= 3'h0;
			first_reg <= 1'b1;
			prev_reg <= '0;
			cnt_reg <= 32'h0;
			recover_reg <= 1'b0;
			// reset forgets a suspend; user must reprogram
			susp_reg <= 1'b0;
			chip_reg <= 1'b0;
			ready_reg <= 1'b0;
			rv_reg <= 1'b0;
			err_reg <= 1'b0;
			data_reg <= '0;
			start_reg <= 1'b0;
			rd_reg <= 1'b0;
			wr_reg <= '0;
		end
		else
		begin
			state_reg <= state_next;
			op_reg <= op_next;
			addr_reg <= addr_next;
			step_reg <= step_next;
			first_reg <= first_next;
			prev_reg <= prev_next;
			cnt_reg <= cnt_next;
			recover_reg <= recover_next;
			susp_reg <= susp_next;
			chip_reg <= chip_next;
			// Ready rises one cycle after reset release
			ready_reg <= (state_reg == M_IDLE && !rv_reg &&
				!(req_valid && ready_reg)) ? 1'b1 : ready_next;
			rv_reg <= rv_next;
			err_reg <= err_next;
			data_reg <= data_next;
			start_reg <= start_next;
			rd_reg <= rd_next;
			wr_reg <= wr_next;
		end
	end

	// Pins come straight from the bus cycle flops
	assign flash_dq_out = pins.dq_out;
	assign flash_dq_oe_n = pins.dq_oe_n;
	assign flash_addr = pins.addr;
	assign flash_we_n = pins.we_n;
	assign flash_oe_n = pins.oe_n;
	assign flash_ce_n = pins.ce_n;
	assign req_ready = ready_reg;
	assign resp_valid = rv_reg;
	assign resp_err = err_reg;
	assign resp_data = data_reg;
	assign suspended = susp_reg;
	assign chip_erase_busy = chip_reg;

	AST_CONFIRM_DATA: assert property (@(posedge core_clk)
		disable iff (!rst_n)
		(start_reg && !rd_reg && op_reg == OP_CONFIRM)
		|-> wr_reg.data[7:0] == CMD_CONFIRM)
		else $error("buffer confirm not 29h");
	AST_SUSPEND_REFUSED: assert property (@(posedge core_clk)
		disable iff (!rst_n)
		(state_reg == M_IDLE && req_valid && ready_reg &&
		req.op == OP_SUSPEND && chip_reg) |=> (rv_reg && err_reg))
		else $error("suspend during chip erase not refused");
	AST_SECTOR_LAST: assert property (@(posedge core_clk)
		disable iff (!rst_n)
		(start_reg && op_reg == OP_SECTOR_ERASE && step_reg == 3'h5)
		|-> (wr_reg.data[7:0] == CMD_SECTOR_ERASE &&
		wr_reg.addr == addr_reg))
		else $error("sector erase sixth write wrong");
	AST_UNLOCK_FIRST: assert property (@(posedge core_clk)
		disable iff (!rst_n)
		(start_reg && step_reg == 3'h0 && (op_reg == OP_CHIP_ERASE ||
		op_reg == OP_SECTOR_ERASE)) |-> (wr_reg.addr == UNLOCK_ADDR1 &&
		wr_reg.data[7:0] == CMD_UNLOCK1))
		else $error("erase sequence not opened by unlock");
	AST_FAIL_RESETS: assert property (@(posedge core_clk)
		disable iff (!rst_n)
		(state_reg == M_RWAIT && bus_done && !first_reg && toggling &&
		failed && op_reg != OP_READ) |-> ##[1:3] (start_reg &&
		wr_reg.data[7:0] == CMD_READ_RESET))
		else $error("failure not followed by read/reset");
	AST_RESET_BEFORE_RESUME: assert property (@(posedge core_clk)
		disable iff (!rst_n)
		(start_reg && op_reg == OP_RESUME && step_reg == 3'h1)
		|-> $past(wr_reg.data[7:0], 2) == CMD_READ_RESET)
		else $error("resume not preceded by read/reset");
	AST_BLANK_CONFIRM: assert property (@(posedge core_clk)
		disable iff (!rst_n)
		(start_reg && op_reg == OP_BLANK_CHECK && step_reg == 3'h2)
		|-> wr_reg.data[7:0] == CMD_CONFIRM)
		else $error("blank check confirm not 29h");
	AST_SUSPEND_FLAG: assert property (@(posedge core_clk)
		disable iff (!rst_n)
		(state_reg == M_LAT && cnt_reg == 32'h1) |=> susp_reg)
		else $error("suspend not recorded after latency");
	AST_CHIP_RESET_CLEARS: assert property (@(posedge core_clk)
		disable iff (!rst_n)
		(state_reg == M_WWAIT && bus_done && op_reg == OP_RESET)
		|=> !chip_reg)
		else $error("reset did not end chip erase tracking");
endmodule

// ---- testbench/fcp_flash_model.sv ----
// Behavioural flash partner: command decode and status polling.
// Assumes clean host strobes; the whole array reads as one fixed word.
`timescale 1ns/10ps
module fcp_flash_model
	import fcp_pkg::*;
#(
	parameter logic [15:0] ARRAY_WORD = 16'h5A3C
)
(
	input wire logic we_n,
	input wire logic oe_n,
	input wire logic ce_n,
	input wire logic dq_oe_n,
	input wire logic [FCP_ADDR_W-1:0] addr,
	input wire logic [FCP_DATA_W-1:0] dq_host,
	input wire logic fail_en,
	input wire logic [7:0] busy_reads,
	output logic [FCP_DATA_W-1:0] dq_wire,
	output int n_writes = 0,
	output logic [7:0] last_cmd = 8'h00,
	output int sectors = 0,
	output logic susp = 1'b0
);
	logic busy = 1'b0;
	logic chip = 1'b0;
	logic prog = 1'b0;
	logic window = 1'b0;
	logic tog = 1'b0;
	logic [7:0] left = 8'h00;
	logic [39:0] hist = 40'h0;
	logic [15:0] rd = 16'h0000;
	logic [15:0] last = 16'h0000;
	logic [7:0] d;

	assign d = dq_host[7:0];
	// Released bus shows the inverse of the last word, never a stale copy
	assign dq_wire = !dq_oe_n ? dq_host : (!oe_n && !ce_n) ? rd : ~last;

	// Command decode at the end of each write strobe
	always @(posedge we_n)
	begin
		if (!ce_n)
		begin
			n_writes = n_writes + 1;
			last_cmd = d;
			if (!(busy && chip))
			begin
				case (d)
					8'hF0: if (!susp) busy = 1'b0;
					// confirm starts; busy time from bench
					8'h29:
					begin
						busy = 1'b1;
						chip = 1'b0;
						prog = hist[15:0] != 16'hEB76;
						window = 1'b0;
						left = busy_reads;
					end
					8'hB0: if (busy)
					begin
						susp = 1'b1;
						window = 1'b0;
					end
					8'h30:
					begin
						if (susp)
							susp = 1'b0;
						else if (busy && window)
							sectors = sectors + 1;
						else if (hist == 40'hAA5580AA55)
						begin
							busy = 1'b1;
							prog = 1'b0;
							window = 1'b1;
							left = busy_reads;
							sectors = 1;
						end
					end
					8'h10: if (hist == 40'hAA5580AA55)
					begin
						busy = 1'b1;
						chip = 1'b1;
						prog = 1'b0;
						left = busy_reads;
					end
					default: ;
				endcase
			end
			hist = {hist[31:0], d};
			// unlock data off its address breaks the sequence
			if ((d == 8'hAA && addr != UNLOCK_ADDR1) ||
				(d == 8'h55 && addr != UNLOCK_ADDR2))
				hist = 40'h0;
		end
	end

	// Read answers, status while busy
	always @(negedge oe_n)
	begin
		if (!ce_n)
		begin
			// array data when idle or suspended
			if (!busy || susp)
				rd = ARRAY_WORD;
			else
			begin
				tog = ~tog;
				window = 1'b0;
				if (left != 8'h00)
					left = left - 8'h01;
				if (left == 8'h00 && !fail_en)
				begin
					busy = 1'b0;
					chip = 1'b0;
					rd = ARRAY_WORD;
				end
				else
					rd = {8'h00, prog & ~ARRAY_WORD[7], tog,
						fail_en && left == 8'h00, 1'b0, !window, 3'h0};
			end
		end
	end

	always @(posedge oe_n)
		last = rd;
endmodule

// ---- testbench/test_fcp_host.sv ----
// Self-checking bench: orders in, answers and flash traffic checked.
// Assumes the behavioural flash partner on the pins.
`timescale 1ns/10ps
module test_fcp_host
	import fcp_pkg::*;
;
	localparam logic [15:0] ARRAY = 16'h5A3C;
	logic core_clk, rst_n, req_valid, req_ready, resp_valid, resp_err;
	logic suspended, chip_erase_busy, dq_oe_n, we_n, oe_n, ce_n, fail_en;
	logic msusp;
	fcp_req_type req;
	logic [15:0] resp_data, dq_in, dq_out;
	logic [21:0] fa;
	logic [7:0] busy_reads, last_cmd;
	int n_writes, sectors, num_errors, checks, w;

	fcp_host #(.POLL_LIMIT(20), .SUSP_WAIT(10)) u_fcp_host (
		.core_clk(core_clk), .rst_n(rst_n), .req_valid(req_valid),
		.req(req), .req_ready(req_ready), .resp_valid(resp_valid),
		.resp_err(resp_err), .resp_data(resp_data),
		.suspended(suspended), .chip_erase_busy(chip_erase_busy),
		.flash_dq_in(dq_in), .flash_dq_out(dq_out),
		.flash_dq_oe_n(dq_oe_n), .flash_addr(fa), .flash_we_n(we_n),
		.flash_oe_n(oe_n), .flash_ce_n(ce_n));

	fcp_flash_model #(.ARRAY_WORD(ARRAY)) u_fcp_flash_model (
		.we_n(we_n), .oe_n(oe_n), .ce_n(ce_n), .dq_oe_n(dq_oe_n),
		.addr(fa), .dq_host(dq_out), .fail_en(fail_en),
		.busy_reads(busy_reads), .dq_wire(dq_in), .n_writes(n_writes),
		.last_cmd(last_cmd), .sectors(sectors), .susp(msusp));

	always #5 core_clk = ~core_clk;

	task tally_and_finish;
		if (num_errors == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// One order through the user port; bounded waits both ways
	task run(input fcp_op_type o, input logic [21:0] a, input logic e);
		int i;
		i = 0;
		while (req_ready !== 1'b1 && i < 2000)
		begin
			@(posedge core_clk);
			#1;
			i++;
		end
		req_valid = 1'b1;
		req = '{op: o, addr: a};
		@(posedge core_clk);
		#1;
		req_valid = 1'b0;
		while (resp_valid !== 1'b1 && i < 4000)
		begin
			@(posedge core_clk);
			#1;
			i++;
		end
		if (i >= 4000)
		begin
			num_errors++;
			tally_and_finish();
		end
		chk({15'h0, resp_err}, {15'h0, e});
	endtask

	initial
	begin
		core_clk = 1'b0;
		rst_n = 1'b0;
		req_valid = 1'b0;
		req = '0;
		fail_en = 1'b0;
		busy_reads = 8'h04;
		num_errors = 0;
		checks = 0;
		repeat (6) @(posedge core_clk);
		#1;
		chk({14'h0, req_ready, suspended}, 16'h0000);
		chk({13'h0, we_n, oe_n, ce_n}, 16'h0007);
		rst_n = 1'b1;
		// Buffer program confirm, then poll to completion
		run(OP_CONFIRM, 22'h000100, 1'b0);
		chk({8'h00, last_cmd}, 16'h0029);
		run(OP_POLL, 22'h000100, 1'b0);
		chk(resp_data, ARRAY);
		// Chip erase; suspend refused without pin traffic
		w = n_writes;
		run(OP_CHIP_ERASE, 22'h000000, 1'b0);
		chk(16'(n_writes - w), 16'h0006);
		chk({15'h0, chip_erase_busy}, 16'h0001);
		run(OP_SUSPEND, 22'h000000, 1'b1);
		chk(16'(n_writes - w), 16'h0006);
		run(OP_POLL, 22'h000000, 1'b0);
		chk({15'h0, chip_erase_busy}, 16'h0000);
		// Two sectors in one window
		w = n_writes;
		run(OP_SECTOR_ERASE, 22'h010000, 1'b0);
		run(OP_ADD_SECTOR, 22'h020000, 1'b0);
		chk(16'(n_writes - w), 16'h0007);
		chk(16'(sectors), 16'h0002);
		run(OP_POLL, 22'h010000, 1'b0);
		// Program suspend, resume, second resume refused
		run(OP_CONFIRM, 22'h000200, 1'b0);
		run(OP_SUSPEND, 22'h000000, 1'b0);
		chk({14'h0, suspended, msusp}, 16'h0003);
		run(OP_RESUME, 22'h000000, 1'b0);
		chk({7'h0, msusp, last_cmd}, 16'h0030);
		run(OP_RESUME, 22'h000000, 1'b1);
		run(OP_POLL, 22'h000200, 1'b0);
		// Suspend inside the window, read elsewhere, resume
		run(OP_SECTOR_ERASE, 22'h030000, 1'b0);
		run(OP_SUSPEND, 22'h000000, 1'b0);
		chk({15'h0, msusp}, 16'h0001);
		run(OP_READ, 22'h050000, 1'b0);
		chk(resp_data, ARRAY);
		run(OP_RESUME, 22'h000000, 1'b0);
		run(OP_POLL, 22'h030000, 1'b0);
		// Failing blank check needs read/reset
		fail_en = 1'b1;
		run(OP_BLANK_CHECK, 22'h040000, 1'b0);
		run(OP_POLL, 22'h040000, 1'b1);
		chk({8'h00, last_cmd}, 16'h00F0);
		chk({10'h0, resp_data[5], 5'h0}, 16'h0020);
		fail_en = 1'b0;
		// Plain read/reset order: one F0 write, no error
		w = n_writes;
		run(OP_RESET, 22'h000000, 1'b0);
		chk(16'(n_writes - w), 16'h0001);
		chk({8'h00, last_cmd}, 16'h00F0);
		tally_and_finish();
	end
endmodule
